// ==== core/dsiab_pkg.sv ====
// Purpose: constants for the indirect access register bank
// Assumes: byte-wide registers, each on one aligned APB word
// Notes: printed offsets are indices; byte address is index times four
package dsiab_pkg;
	localparam int DSIAB_ADDR_W = 12;
	localparam int DSIAB_IDX_W = 8;
	localparam int DSIAB_IDX_SH = 2;
	localparam logic [7:0] DSIAB_IDX_LOW = 8'he5;
	localparam logic [7:0] DSIAB_IDX_HIGH = 8'he6;
	localparam logic [7:0] DSIAB_IDX_MODE = 8'he8;
	localparam logic [7:0] DSIAB_IDX_LOOP = 8'hf3;
	localparam logic [7:0] DSIAB_MODE_ADDR = 8'h00;
	localparam logic [7:0] DSIAB_MODE_DATA = 8'h01;
	localparam logic [7:0] DSIAB_MODE_CTRL = 8'h02;
	localparam logic [7:0] DSIAB_MODE_RST = 8'h00;
	localparam logic [7:0] DSIAB_SHARED_RST = 8'h00;
	localparam logic [7:0] DSIAB_LOOP_RST = 8'h00;
	localparam int DSIAB_LOOP_UA_PER_CNT = 1100;
	localparam int DSIAB_CFG_N = 16;
	// Plain read/write registers: index and reset value
	localparam logic [7:0] DSIAB_CFG_IDX [DSIAB_CFG_N] = '{
		8'he2, 8'he3, 8'he4, 8'heb, 8'hec, 8'hed, 8'hee, 8'hf0,
		8'hf1, 8'hf2, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9};
	localparam logic [7:0] DSIAB_CFG_RST [DSIAB_CFG_N] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h88, 8'h19, 8'h16, 8'h40,
		8'h0c, 8'h00, 8'h0f, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h20};
endpackage

// ==== core/dsiab_shared_if.sv ====
// Purpose: carries shared location strobes between bank and unit
// Assumes: one clock, strobes last one cycle
// Notes: unit holds the loaded processor words
interface dsiab_shared_if;
	logic wr_low;
	logic wr_high;
	logic [7:0] wdata;
	logic [7:0] mode;
	logic [15:0] addr;
	logic [13:0] data;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	modport bank (output wr_low, output wr_high, output wdata,
		output mode, input addr, input data, input ctrl_a, input ctrl_b);
	modport unit (input wr_low, input wr_high, input wdata,
		input mode, output addr, output data, output ctrl_a,
		output ctrl_b);
endinterface

// ==== core/dsiab_shared_unit.sv ====
// Purpose: mode dependent loading of the shared locations
// Assumes: strobes come from the bank on the same clock
// Notes: writes in undefined modes change nothing
module dsiab_shared_unit
	import dsiab_pkg::*;
(
	input logic i_clock,
	input logic i_rst_n,
	dsiab_shared_if.unit sh
);
	logic [15:0] addr_reg;
	logic [13:0] data_reg;
	logic [7:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;

	// Processor address halves
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			addr_reg <= {DSIAB_SHARED_RST, DSIAB_SHARED_RST};
		end
		else if (sh.mode == DSIAB_MODE_ADDR)
		begin
			if (sh.wr_low)
				addr_reg[7:0] <= sh.wdata;
			if (sh.wr_high)
				addr_reg[15:8] <= sh.wdata;
		end
	end

	// Processor data word halves
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			data_reg <= {DSIAB_SHARED_RST[5:0], DSIAB_SHARED_RST};
		end
		else if (sh.mode == DSIAB_MODE_DATA)
		begin
			if (sh.wr_low)
				data_reg[7:0] <= sh.wdata;
			if (sh.wr_high)
				data_reg[13:8] <= sh.wdata[5:0];
		end
	end

	// Write-only control bytes
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_a_reg <= DSIAB_SHARED_RST;
			ctrl_b_reg <= DSIAB_SHARED_RST;
		end
		else if (sh.mode == DSIAB_MODE_CTRL)
		begin
			if (sh.wr_low)
				ctrl_a_reg <= sh.wdata;
			if (sh.wr_high)
				ctrl_b_reg <= sh.wdata;
		end
	end

	assign sh.addr = addr_reg;
	assign sh.data = data_reg;
	assign sh.ctrl_a = ctrl_a_reg;
	assign sh.ctrl_b = ctrl_b_reg;

	// -------------------------------------------------
	// Checks
	// -------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	addr_low_load_a: assert property (
		sh.wr_low && sh.mode == DSIAB_MODE_ADDR
		|=> addr_reg[7:0] == $past(sh.wdata))
		else $error("address low byte not loaded");
	addr_high_load_a: assert property (
		sh.wr_high && sh.mode == DSIAB_MODE_ADDR
		|=> addr_reg[15:8] == $past(sh.wdata))
		else $error("address high byte not loaded");
	data_low_load_a: assert property (
		sh.wr_low && sh.mode == DSIAB_MODE_DATA
		|=> data_reg[7:0] == $past(sh.wdata) && $stable(addr_reg))
		else $error("data low byte not loaded");
	data_high_load_a: assert property (
		sh.wr_high && sh.mode == DSIAB_MODE_DATA
		|=> data_reg[13:8] == $past(sh.wdata[5:0]))
		else $error("data high bits not loaded");
	ctrl_bytes_load_a: assert property (
		sh.mode == DSIAB_MODE_CTRL && (sh.wr_low || sh.wr_high)
		|=> $stable(data_reg) && $stable(addr_reg)
		&& ($past(sh.wr_low) -> ctrl_a_reg == $past(sh.wdata)))
		else $error("control byte not loaded");
	ctrl_b_load_a: assert property (
		sh.wr_high && sh.mode == DSIAB_MODE_CTRL
		|=> ctrl_b_reg == $past(sh.wdata) && $stable(ctrl_a_reg))
		else $error("control byte b not loaded");
	addr_hold_a: assert property (
		sh.mode != DSIAB_MODE_ADDR |=> $stable(addr_reg))
		else $error("address changed outside address mode");
endmodule

// ==== core/dsiab_top.sv ====
// Purpose: APB register bank with mode switched shared locations
// Assumes: APB master on i_clock, pready after one wait state
// Notes: loop current input is asynchronous and resynchronised
//
// Decided for this implementation: the APB slave port.
module dsiab_top
	import dsiab_pkg::*;
(
	input logic i_clock,
	input logic i_rst_n,
	input logic i_psel,
	input logic i_penable,
	input logic i_pwrite,
	input logic [DSIAB_ADDR_W-1:0] i_paddr,
	input logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input logic [7:0] i_proc_status,
	input logic [7:0] i_loop_current,
	output logic [15:0] o_proc_addr,
	output logic [13:0] o_proc_data,
	output logic [7:0] o_proc_control_a,
	output logic [7:0] o_proc_control_b,
	output logic [7:0] o_shared_access_mode,
	output logic [DSIAB_CFG_N*8-1:0] o_cfg_bank
);
	// -------------------------------------------------
	// Declarations
	// -------------------------------------------------
	dsiab_shared_if sh ();

	logic [7:0] mode_reg;
	logic [7:0] cfg_reg [DSIAB_CFG_N];
	logic [7:0] loop_meta_reg;
	logic [7:0] loop_level_reg;
	logic [7:0] loop_sync_reg;
	logic [7:0] loop_prev_reg;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [DSIAB_IDX_W-1:0] idx;
	logic aligned;
	logic mapped;
	logic [7:0] rd_byte;
	logic access;
	logic commit;
	logic wr_commit;

	// -------------------------------------------------
	// Bus decode
	// -------------------------------------------------

	// Word index; lane bits and bits above the index must be zero
	assign idx = i_paddr[DSIAB_IDX_SH +: DSIAB_IDX_W];
	assign aligned = (i_paddr[DSIAB_IDX_SH-1:0] == 2'h0)
		&& (i_paddr[DSIAB_ADDR_W-1:DSIAB_IDX_SH+DSIAB_IDX_W] == 2'h0);

	// First access cycle samples, second completes
	assign access = i_psel && i_penable;
	assign commit = access && pready_reg;
	assign wr_commit = commit && i_pwrite && !pslverr_reg;

	// Read multiplexer and map check
	always_comb
	begin
		mapped = 1'b0;
		rd_byte = 8'h00;
		for (int i = 0; i < DSIAB_CFG_N; i++)
		begin
			if (idx == DSIAB_CFG_IDX[i])
			begin
				mapped = 1'b1;
				rd_byte = cfg_reg[i];
			end
		end
		if (idx == DSIAB_IDX_MODE)
		begin
			mapped = 1'b1;
			rd_byte = mode_reg;
		end
		if (idx == DSIAB_IDX_LOW)
		begin
			mapped = 1'b1;
			if (mode_reg == DSIAB_MODE_CTRL)
				rd_byte = i_proc_status;
		end
		if (idx == DSIAB_IDX_HIGH)
		begin
			mapped = 1'b1;
		end
		if (idx == DSIAB_IDX_LOOP)
		begin
			mapped = 1'b1;
			rd_byte = loop_level_reg;
		end
		if (!aligned)
		begin
			mapped = 1'b0;
			rd_byte = 8'h00;
		end
	end

	// -------------------------------------------------
	// Bus answer
	// -------------------------------------------------

	// Answer values prepared in the first access cycle
	always_comb
	begin
		pready_next = access && !pready_reg;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		if (access && !pready_reg)
		begin
			pslverr_next = !mapped;
			prdata_next = i_pwrite ? 32'h0 : {24'h0, rd_byte};
		end
		else if (commit)
		begin
			prdata_next = 32'h0;
		end
	end

	// Answer registers
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else
		begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// -------------------------------------------------
	// Mode register
	// -------------------------------------------------

	// Selects the meaning of both shared locations
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			mode_reg <= DSIAB_MODE_RST;
		else if (wr_commit && idx == DSIAB_IDX_MODE)
			mode_reg <= i_pwdata[7:0];
	end

	// -------------------------------------------------
	// Plain configuration registers
	// -------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < DSIAB_CFG_N; g++)
		begin : cfg_gen
			// One byte register per printed index
			always_ff @(posedge i_clock or negedge i_rst_n)
			begin
				if (!i_rst_n)
					cfg_reg[g] <= DSIAB_CFG_RST[g];
				else if (wr_commit && idx == DSIAB_CFG_IDX[g])
					cfg_reg[g] <= i_pwdata[7:0];
			end
			assign o_cfg_bank[g*8 +: 8] = cfg_reg[g];

			cfg_write_a: assert property (@(posedge i_clock)
				disable iff (!i_rst_n)
				wr_commit && idx == DSIAB_CFG_IDX[g]
				|=> cfg_reg[g] == $past(i_pwdata[7:0]))
				else $error("configuration byte not written");
		end
	endgenerate

	// -------------------------------------------------
	// Loop current level
	// -------------------------------------------------

	// Two stage resynchroniser, then one more sample to compare
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			loop_meta_reg <= DSIAB_LOOP_RST;
			loop_sync_reg <= DSIAB_LOOP_RST;
			loop_prev_reg <= DSIAB_LOOP_RST;
		end
		else
		begin
			loop_meta_reg <= i_loop_current;
			loop_sync_reg <= loop_meta_reg;
			loop_prev_reg <= loop_sync_reg;
		end
	end

	// Level takes only a word seen unchanged on two edges,
	// so a word caught while its bits move never reaches the bus
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			loop_level_reg <= DSIAB_LOOP_RST;
		else if (loop_sync_reg == loop_prev_reg)
			loop_level_reg <= loop_sync_reg;
	end

	// -------------------------------------------------
	// Shared locations
	// -------------------------------------------------

	// Strobes to the unit; mode decides the target there
	assign sh.wr_low = wr_commit && idx == DSIAB_IDX_LOW;
	assign sh.wr_high = wr_commit && idx == DSIAB_IDX_HIGH;
	assign sh.wdata = i_pwdata[7:0];
	assign sh.mode = mode_reg;

	dsiab_shared_unit u_shared (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.sh(sh)
	);

	// -------------------------------------------------
	// Outputs
	// -------------------------------------------------

	// All driven by flip-flops
	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_proc_addr = sh.addr;
	assign o_proc_data = sh.data;
	assign o_proc_control_a = sh.ctrl_a;
	assign o_proc_control_b = sh.ctrl_b;
	assign o_shared_access_mode = mode_reg;

	// -------------------------------------------------
	// Checks
	// -------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// Setup phase of a read of a given index
	sequence read_setup(logic [7:0] where);
		i_psel && !i_penable && !i_pwrite && aligned && idx == where;
	endsequence

	// First access cycle with the request held
	sequence first_access;
		access && !pready_reg;
	endsequence

	// Closing access cycle of a refused request
	sequence refused_close;
		commit && pslverr_reg;
	endsequence

	bus_wait_state_a: assert property (
		first_access |=> o_pready ##1 !o_pready)
		else $error("pready not one cycle after first access");

	mode_write_a: assert property (
		wr_commit && idx == DSIAB_IDX_MODE
		|=> o_shared_access_mode == $past(i_pwdata[7:0]))
		else $error("mode register not written");

	status_read_a: assert property (
		read_setup(DSIAB_IDX_LOW) ##1
		(first_access and (mode_reg == DSIAB_MODE_CTRL))
		|=> o_pready && o_prdata == {24'h0, $past(i_proc_status)})
		else $error("status byte not returned in mode two");

	loop_read_a: assert property (
		read_setup(DSIAB_IDX_LOOP) ##1 first_access
		|=> o_pready && o_prdata[7:0] == $past(loop_level_reg)
		&& o_prdata[31:8] == 24'h0)
		else $error("loop current not returned");

	loop_readonly_a: assert property (
		wr_commit && idx == DSIAB_IDX_LOOP
		|=> loop_level_reg == $past(loop_sync_reg == loop_prev_reg
		? loop_sync_reg : loop_level_reg))
		else $error("loop current changed by write");

	shared_low_blank_a: assert property (
		read_setup(DSIAB_IDX_LOW) ##1
		(first_access and (mode_reg != DSIAB_MODE_CTRL))
		|=> o_pready && o_prdata == 32'h0)
		else $error("write-only location read not zero");

	high_read_blank_a: assert property (
		read_setup(DSIAB_IDX_HIGH) ##1 first_access
		|=> o_pready && o_prdata == 32'h0)
		else $error("write-only high location read not zero");

	// Refused accesses answer with an error and change nothing
	pslverr_refuse_a: assert property (
		access && !pready_reg && !mapped |=> o_pready && o_pslverr)
		else $error("refused access answered without error");

	refused_write_a: assert property (
		refused_close ##0 i_pwrite
		|=> $stable(o_shared_access_mode) && $stable(o_cfg_bank))
		else $error("refused write changed a register");

	// Write answers carry no data
	write_no_read_a: assert property (
		access && !pready_reg && i_pwrite
		|=> o_prdata == 32'h0)
		else $error("write answer carried data");

	// Answer stands one cycle, then the bus returns to idle
	answer_clear_a: assert property (
		o_pready |=> o_prdata == 32'h0 && !o_pslverr)
		else $error("answer did not clear after one cycle");

	// No answer outside an access
	pready_idle_a: assert property (
		!access |=> !o_pready)
		else $error("pready without an access cycle");

	// Mode only moves on its own write
	mode_hold_a: assert property (
		!(wr_commit && idx == DSIAB_IDX_MODE)
		|=> $stable(o_shared_access_mode))
		else $error("mode changed without a mode write");

	// Loop level follows only settled samples
	loop_filter_a: assert property (
		loop_sync_reg != loop_prev_reg |=> $stable(loop_level_reg))
		else $error("loop level took an unsettled sample");

	loop_follow_a: assert property (
		loop_sync_reg == loop_prev_reg
		|=> loop_level_reg == $past(loop_sync_reg))
		else $error("loop level missed a settled sample");
endmodule

// ==== sim/dsiab_host_model.sv ====
// Purpose: host model issuing APB transfers to the bank
// Assumes: one transfer at a time, called by the bench
// Notes: idle address and data inverted, never left stale
module dsiab_host_model
	import dsiab_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [DSIAB_ADDR_W-1:0] o_paddr,
	output logic [31:0] o_pwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial
	begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = '0;
		o_pwdata = '0;
	end

	// Setup, access held until pready, then release
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] rd, output logic err);
		@(posedge i_clock);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= wr;
		o_paddr <= a;
		o_pwdata <= {24'h000000, d};
		@(posedge i_clock);
		o_penable <= 1'b1;
		do
			@(posedge i_clock);
		while (i_pready !== 1'b1);
		rd = i_prdata[7:0];
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~a;
		o_pwdata <= ~{24'h000000, d};
	endtask
endmodule

// ==== sim/dsp_indirect_access_bank_tb.sv ====
// Purpose: self-checking bench for the indirect access bank
// Assumes: host model drives APB, bench drives processor inputs
// Notes: expected values worked out here, never read back
module dsp_indirect_access_bank_tb
	import dsiab_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n;
	logic psel, pen, pwr, rdy, slverr, erv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] status, loop_cur, rdv, ctl_a, ctl_b, mode;
	logic [15:0] p_addr;
	logic [13:0] p_data;
	logic [DSIAB_CFG_N*8-1:0] cfg_bank;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	dsiab_top DUT (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy),
		.o_pslverr(slverr), .i_proc_status(status),
		.i_loop_current(loop_cur), .o_proc_addr(p_addr),
		.o_proc_data(p_data), .o_proc_control_a(ctl_a),
		.o_proc_control_b(ctl_b), .o_shared_access_mode(mode),
		.o_cfg_bank(cfg_bank));
	dsiab_host_model host (.i_clock(clk), .i_pready(rdy),
		.i_prdata(prdata), .i_pslverr(slverr), .o_psel(psel),
		.o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
		.o_pwdata(pwdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write, then let the write land
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		host.xfer(1'b1, {2'b00, idx, 2'b00}, d, rdv, erv);
		chk("wr err", 16'h0000, {15'h0000, erv});
		@(negedge clk);
	endtask

	task automatic rdc(input string nm, input logic [7:0] idx,
		input logic [7:0] e);
		host.xfer(1'b0, {2'b00, idx, 2'b00}, 8'h00, rdv, erv);
		chk(nm, {8'h00, e}, {8'h00, rdv});
		chk("rd err", 16'h0000, {15'h0000, erv});
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		rst_n = 1'b0;
		status = 8'h00;
		loop_cur = 8'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdc("mode rst", DSIAB_IDX_MODE, 8'h00);
		rdc("loop rst", DSIAB_IDX_LOOP, 8'h00);
		chk("addr rst", 16'h0000, p_addr);
		for (int g = 0; g < DSIAB_CFG_N; g++)
		begin
			rdc("cfg rst", DSIAB_CFG_IDX[g], DSIAB_CFG_RST[g]);
			wr(DSIAB_CFG_IDX[g], 8'h5a ^ g[7:0]);
			chk("cfg out", {8'h00, 8'h5a ^ g[7:0]},
				{8'h00, cfg_bank[g*8 +: 8]});
			rdc("cfg rw", DSIAB_CFG_IDX[g], 8'h5a ^ g[7:0]);
		end
		// Address mode
		wr(DSIAB_IDX_MODE, 8'h00);
		wr(DSIAB_IDX_LOW, 8'ha5);
		wr(DSIAB_IDX_HIGH, 8'h3c);
		chk("addr", 16'h3ca5, p_addr);
		// Data mode
		wr(DSIAB_IDX_MODE, 8'h01);
		rdc("mode rd", DSIAB_IDX_MODE, 8'h01);
		chk("mode out", 16'h0001, {8'h00, mode});
		wr(DSIAB_IDX_LOW, 8'h5a);
		wr(DSIAB_IDX_HIGH, 8'hff);
		chk("data", 16'h3f5a, {2'b00, p_data});
		chk("addr kept", 16'h3ca5, p_addr);
		rdc("low rd m1", DSIAB_IDX_LOW, 8'h00);
		// Control mode
		wr(DSIAB_IDX_MODE, 8'h02);
		@(posedge clk) status <= 8'h96;
		rdc("status", DSIAB_IDX_LOW, 8'h96);
		@(posedge clk) status <= 8'h69;
		rdc("status live", DSIAB_IDX_LOW, 8'h69);
		rdc("high rd", DSIAB_IDX_HIGH, 8'h00);
		wr(DSIAB_IDX_LOW, 8'h11);
		wr(DSIAB_IDX_HIGH, 8'h22);
		chk("ctl a", 16'h0011, {8'h00, ctl_a});
		chk("ctl b", 16'h0022, {8'h00, ctl_b});
		chk("data kept", 16'h3f5a, {2'b00, p_data});
		// Undefined mode drops writes
		wr(DSIAB_IDX_MODE, 8'h03);
		wr(DSIAB_IDX_LOW, 8'h77);
		chk("ctl a kept", 16'h0011, {8'h00, ctl_a});
		chk("addr kept3", 16'h3ca5, p_addr);
		// Loop current, read only
		@(posedge clk) loop_cur <= 8'hc3;
		repeat (4) @(posedge clk);
		rdc("loop", DSIAB_IDX_LOOP, 8'hc3);
		wr(DSIAB_IDX_LOOP, 8'h00);
		rdc("loop ro", DSIAB_IDX_LOOP, 8'hc3);
		// Unmapped and misaligned
		host.xfer(1'b0, 12'h000, 8'h00, rdv, erv);
		chk("unmapped", 16'h0100, {7'h00, erv, rdv});
		host.xfer(1'b1, 12'h3a1, 8'h05, rdv, erv);
		chk("misalign", 16'h0001, {15'h0000, erv});
		host.xfer(1'b0, 12'hfa0, 8'h00, rdv, erv);
		chk("range", 16'h0100, {7'h00, erv, rdv});
		rdc("mode kept", DSIAB_IDX_MODE, 8'h03);
		complete_run();
	end
endmodule
